/* src/fnd_pkg.sv */
package fnd_pkg;

  // ---------------------------------------------------------------
  // Setting word layout
  // ---------------------------------------------------------------
  localparam int SET_W        = 24;
  localparam int SEL_LSB      = 0;
  localparam int FRAC_LSB     = 2;
  localparam int FRAC_W       = 4;
  localparam int DIV_LSB      = 6;
  localparam int DIV_W        = 15;
  localparam int MSS_BIT      = 21;
  localparam int PWDN_BIT     = 22;
  localparam int CRST_BIT     = 23;
  localparam logic [1:0] SEL_RF_WORD = 2'h3;
  localparam logic [SET_W-1:0] SETTING_RST = 24'h000000;

  // ---------------------------------------------------------------
  // Prescaler and fraction moduli
  // ---------------------------------------------------------------
  localparam logic [4:0] PRE_LOW_P     = 5'h08;
  localparam logic [4:0] PRE_HIGH_P    = 5'h10;
  localparam logic [4:0] FRAC_MOD_15   = 5'h0F;
  localparam logic [4:0] FRAC_MOD_16   = 5'h10;
  localparam logic [3:0] FRAC_ALL_ONES = 4'hF;
  localparam logic [10:0] COARSE_GAP   = 11'h002;

  // ---------------------------------------------------------------
  // Lock filter
  // ---------------------------------------------------------------
  localparam int LOCK_NARROW_NS = 15;
  localparam int LOCK_WIDE_NS   = 30;
  localparam logic [2:0] LOCK_CYCLES = 3'h5;

  // ---------------------------------------------------------------
  // APB register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFS_SETTING = 8'h10;
  localparam logic [7:0] OFS_DECODE  = 8'h14;
  localparam logic [7:0] OFS_LOCK    = 8'h18;
  localparam logic CTRL_MOD16_RST    = 1'b0;

  // Event bits of status, enable and clear
  localparam int EV_LOAD   = 0;
  localparam int EV_LOCK   = 1;
  localparam int EV_UNLOCK = 2;
  localparam int EV_BAD    = 3;
  localparam int EV_W      = 4;
  localparam logic [EV_W-1:0] IRQ_EN_RST = 4'h0;

  typedef struct packed {
    logic [10:0] coarse;
    logic [1:0]  quad;
    logic [1:0]  unit;
  } fnd_split_s;

  // Splits a divide value into coarse, quad-step and unit-step counts
  function automatic fnd_split_s fnd_split(input logic [DIV_W-1:0] value, input logic high_band);
    fnd_split_s s;
    s.unit = value[1:0];
    if (high_band) begin
      s.coarse = value[14:4];
      s.quad   = value[3:2];
    end else begin
      s.coarse = value[13:3];
      s.quad   = {1'b0, value[2]};
    end
    return s;
  endfunction

endpackage

/* src/fnd_ser_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface fnd_ser_if;
  logic [23:0] word;
  logic        load;
  modport rx   (output word, output load);
  modport core (input word, input load);
endinterface

`default_nettype wire

/* src/fnd_ser_rx.sv */
`timescale 1ns/1ps
`default_nettype none

module fnd_ser_rx
  import fnd_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Three-wire pins
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic ser_le,
  // Word to the core
  fnd_ser_if.rx     link
);

  typedef struct packed {
    logic [1:0]       clk_s;
    logic [1:0]       dat_s;
    logic [1:0]       le_s;
    logic             clk_prev;
    logic             le_prev;
    logic [SET_W-1:0] shift;
    logic [SET_W-1:0] word;
    logic             load;
  } fnd_rx_s;

  fnd_rx_s rx_reg;
  fnd_rx_s rx_next;

  // ---------------------------------------------------------------
  // Shift and latch
  // ---------------------------------------------------------------
  // Data and clock share one synchroniser depth, so setup at the pin
  // carries over to the sampled edge.
  always_comb begin
    rx_next          = rx_reg;
    rx_next.clk_s    = {rx_reg.clk_s[0], ser_clk};
    rx_next.dat_s    = {rx_reg.dat_s[0], ser_data};
    rx_next.le_s     = {rx_reg.le_s[0], ser_le};
    rx_next.clk_prev = rx_reg.clk_s[1];
    rx_next.le_prev  = rx_reg.le_s[1];
    rx_next.load     = 1'b0;
    if (rx_reg.clk_s[1] && !rx_reg.clk_prev) begin
      rx_next.shift = {rx_reg.shift[SET_W-2:0], rx_reg.dat_s[1]};
    end
    if (rx_reg.le_s[1] && !rx_reg.le_prev) begin
      rx_next.word = rx_reg.shift;
      rx_next.load = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  assign link.word = rx_reg.word;
  assign link.load = rx_reg.load;

endmodule // fnd_ser_rx

`default_nettype wire

/* src/fnd_top.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Divide value sits in word bits 6-20
// - High band uses the same field placement
// - Fraction numerator bits 2-5, ones need 16
// - Split value into coarse, quad, unit counts
// - Base modulus 8 low band, 16 high
// - Fraction adds numerator over modulus on average
// - Serial bits MSB first on rising clock
// - Lock after 5 good reference cycles
// - Locked uses wide window; exceed drops lock
// - Latch word only when low bits are 11
// - Select bit one picks high band
module fnd_top
  import fnd_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Three-wire setting link
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_le,
  // Divided clocks and phase comparator
  input  wire logic        ref_div_clk,
  input  wire logic        fb_div_clk,
  input  wire logic        phase_err,
  // Prescaler presets
  output logic [10:0]      coarse_count,
  output logic [1:0]       quad_count,
  output logic [1:0]       unit_count,
  output logic             modulus_set_select,
  output logic             frac_carry,
  // Loop control and lock
  output logic             power_down,
  output logic             counter_reset,
  output logic             lock_detect,
  output logic             lock_window_wide,
  output logic             irq
);

  typedef enum logic {
    LK_HUNT,
    LK_LOCKED
  } fnd_lock_e;

  typedef struct packed {
    logic [1:0]       ref_s;
    logic             ref_prev;
    logic [1:0]       fb_s;
    logic             fb_prev;
    logic [1:0]       err_s;
    logic [SET_W-1:0] setting;
    logic             mod16;
    logic [3:0]       acc;
    logic             carry;
    fnd_split_s       split;
    fnd_lock_e        lk;
    logic [2:0]       cnt;
    logic             lock;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  irq_en;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } fnd_state_s;

  fnd_state_s st_reg;
  fnd_state_s st_next;

  fnd_ser_if ser ();

  fnd_ser_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .ser_clk  (ser_clk),
    .ser_data (ser_data),
    .ser_le   (ser_le),
    .link     (ser)
  );

  // ---------------------------------------------------------------
  // Field views of the latched word, select bits from the incoming word
  // ---------------------------------------------------------------
  logic [DIV_W-1:0]  rf_divide_value;
  logic [FRAC_W-1:0] fraction_numerator;
  logic [1:0]        word_select_bits;
  logic              setting_high_band;
  logic              pwdn;
  logic              crst;

  assign rf_divide_value    = st_reg.setting[DIV_LSB +: DIV_W];
  assign fraction_numerator = st_reg.setting[FRAC_LSB +: FRAC_W];
  assign word_select_bits   = ser.word[SEL_LSB +: 2];
  assign setting_high_band  = st_reg.setting[MSS_BIT];
  assign pwdn               = st_reg.setting[PWDN_BIT];
  assign crst               = st_reg.setting[CRST_BIT];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [EV_W-1:0] ev;
    fnd_split_s      chk;
    logic [1:0]      big;
    logic [4:0]      sum;
    logic [4:0]      modv;
    logic            ref_rise;
    logic            fb_rise;
    logic            setup_ph;
    logic            access_ph;
    ev        = '0;
    chk       = '0;
    big       = '0;
    sum       = '0;
    modv      = '0;
    ref_rise  = 1'b0;
    fb_rise   = 1'b0;
    setup_ph  = 1'b0;
    access_ph = 1'b0;
    st_next   = st_reg;

    // Pin synchronisers
    st_next.ref_s    = {st_reg.ref_s[0], ref_div_clk};
    st_next.fb_s     = {st_reg.fb_s[0], fb_div_clk};
    st_next.err_s    = {st_reg.err_s[0], phase_err};
    st_next.ref_prev = st_reg.ref_s[1];
    st_next.fb_prev  = st_reg.fb_s[1];
    ref_rise = st_reg.ref_s[1] && !st_reg.ref_prev;
    fb_rise  = st_reg.fb_s[1] && !st_reg.fb_prev;

    // Latch a new setting word and check its ratio
    if (ser.load && (word_select_bits == SEL_RF_WORD)) begin
      st_next.setting = ser.word;
      ev[EV_LOAD] = 1'b1;
      chk = fnd_split(ser.word[DIV_LSB +: DIV_W], ser.word[MSS_BIT]);
      big = (chk.quad > chk.unit) ? chk.quad : chk.unit;
      if (chk.coarse < ({9'h000, big} + COARSE_GAP)) begin
        ev[EV_BAD] = 1'b1;
      end
      // Without modulus 16 the all-ones numerator would carry every cycle
      if (!st_reg.mod16 && (ser.word[FRAC_LSB +: FRAC_W] == FRAC_ALL_ONES)) begin
        ev[EV_BAD] = 1'b1;
      end
    end

    // Presets follow the latched word; N = P*C + 4*B + A
    st_next.split = fnd_split(rf_divide_value, setting_high_band);

    // Fraction accumulator, one step per feedback cycle
    st_next.carry = 1'b0;
    modv = st_reg.mod16 ? FRAC_MOD_16 : FRAC_MOD_15;
    if (pwdn || crst) begin
      st_next.acc = '0;
    end else if (fb_rise) begin
      sum = {1'b0, st_reg.acc} + {1'b0, fraction_numerator};
      if (sum >= modv) begin
        sum           = sum - modv;
        st_next.carry = 1'b1;
      end
      st_next.acc = sum[3:0];
    end

    // Lock filter, judged once per reference cycle
    if (pwdn) begin
      st_next.lk   = LK_HUNT;
      st_next.cnt  = '0;
      st_next.lock = 1'b0;
    end else if (ref_rise) begin
      case (st_reg.lk)
        LK_HUNT: begin
          if (st_reg.err_s[1]) begin
            st_next.cnt = '0;
          end else if (st_reg.cnt == (LOCK_CYCLES - 3'h1)) begin
            st_next.lk    = LK_LOCKED;
            st_next.lock  = 1'b1;
            st_next.cnt   = '0;
            ev[EV_LOCK]   = 1'b1;
          end else begin
            st_next.cnt = st_reg.cnt + 3'h1;
          end
        end
        LK_LOCKED: begin
          if (st_reg.err_s[1]) begin
            st_next.lk    = LK_HUNT;
            st_next.lock  = 1'b0;
            st_next.cnt   = '0;
            ev[EV_UNLOCK] = 1'b1;
          end
        end
        default: begin
          st_next.lk   = LK_HUNT;
          st_next.cnt  = '0;
          st_next.lock = 1'b0;
        end
      endcase
    end

    // APB: answer registered in the setup cycle, ready in the access cycle
    setup_ph  = psel && !penable;
    access_ph = psel && penable && st_reg.pready;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (setup_ph) begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      case (paddr)
        OFS_CTRL:    st_next.prdata = {31'h00000000, st_reg.mod16};
        OFS_STATUS:  st_next.prdata = {28'h0000000, st_reg.status};
        OFS_IRQ_EN:  st_next.prdata = {28'h0000000, st_reg.irq_en};
        OFS_IRQ_CLR: st_next.prdata = '0;
        OFS_SETTING: st_next.prdata = {8'h00, st_reg.setting};
        OFS_DECODE:  st_next.prdata = {13'h0000, fraction_numerator, st_reg.split};
        OFS_LOCK:    st_next.prdata = {27'h0000000, st_reg.cnt, st_reg.lk == LK_LOCKED, st_reg.lock};
        default:     st_next.pslverr = 1'b1;
      endcase
    end
    if (access_ph && pwrite && !st_reg.pslverr) begin
      case (paddr)
        OFS_CTRL:    st_next.mod16  = pwdata[0];
        OFS_IRQ_EN:  st_next.irq_en = pwdata[EV_W-1:0];
        OFS_IRQ_CLR: st_next.status = st_reg.status & ~pwdata[EV_W-1:0];
        default:     st_next.mod16  = st_reg.mod16;
      endcase
    end

    // A new event in the clearing cycle survives the clear
    st_next.status = st_next.status | ev;
    st_next.irq    = |(st_next.status & st_next.irq_en);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.setting <= SETTING_RST;
      st_reg.mod16   <= CTRL_MOD16_RST;
      st_reg.irq_en  <= IRQ_EN_RST;
      st_reg.lk      <= LK_HUNT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pready             = st_reg.pready;
  assign prdata             = st_reg.prdata;
  assign pslverr            = st_reg.pslverr;
  assign coarse_count       = st_reg.split.coarse;
  assign quad_count         = st_reg.split.quad;
  assign unit_count         = st_reg.split.unit;
  assign modulus_set_select = st_reg.setting[MSS_BIT];
  assign frac_carry         = st_reg.carry;
  assign power_down         = st_reg.setting[PWDN_BIT];
  assign counter_reset      = st_reg.setting[CRST_BIT];
  assign lock_detect        = st_reg.lock;
  // Analog window choice: narrow while hunting, wide once locked
  assign lock_window_wide   = st_reg.lock;
  assign irq                = st_reg.irq;

endmodule // fnd_top

`default_nettype wire

/* verification/fnd_host.sv */
`timescale 1ns/1ps
`default_nettype none

module fnd_host (
  // Clock
  input  wire logic pclk,
  // Three-wire link
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end

  // -------------------------------------------------
  // Word transfer, 800 ns link period
  // -------------------------------------------------
  // Data idles at the inverse of the last bit so a held value cannot pass
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (4) @(posedge pclk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ser_clk <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    ser_le <= 1'b1;
    repeat (4) @(posedge pclk);
    ser_le <= 1'b0;
    ser_data <= ~w[0];
    repeat (12) @(posedge pclk);
  endtask
endmodule // fnd_host

`default_nettype wire

/* verification/fnd_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module fnd_chk (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Watched ports
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pready,
  input  wire logic       pslverr,
  input  wire logic       phase_err,
  input  wire logic [1:0] quad_count,
  input  wire logic       modulus_set_select,
  input  wire logic       frac_carry,
  input  wire logic       power_down,
  input  wire logic       lock_detect,
  input  wire logic       lock_window_wide
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // -------------------------------------------------
  // Properties
  // -------------------------------------------------
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_window_tracks_lock: assert property (lock_window_wide == lock_detect)
    else $error("window select differs from lock");
  a_pwdn_no_lock: assert property (power_down && $past(power_down) |-> !lock_detect)
    else $error("lock high in power down");
  a_lock_gain_up: assert property ($rose(lock_detect) |-> !power_down && !$past(power_down))
    else $error("lock gained around power down");
  a_lock_holds: assert property ((lock_detect && !phase_err && !power_down) [*6] |=> lock_detect || power_down)
    else $error("lock lost without phase error");
  a_low_band_quad: assert property ((!modulus_set_select) [*3] |-> !quad_count[1])
    else $error("quad count too big in low band");
  a_carry_single: assert property (frac_carry |=> !frac_carry)
    else $error("carry longer than one cycle");
  a_pwdn_no_carry: assert property (power_down [*2] |-> !frac_carry)
    else $error("carry during power down");
endmodule // fnd_chk

bind fnd_top fnd_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .phase_err, .quad_count,
  .modulus_set_select, .frac_carry, .power_down, .lock_detect, .lock_window_wide);

`default_nettype wire

/* verification/tb_fnd_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_fnd_top;
  import fnd_pkg::*;

  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, last_err;
  logic        ser_clk, ser_data, ser_le;
  logic        ref_div_clk, fb_div_clk, phase_err;
  logic [10:0] coarse_count;
  logic [1:0]  quad_count, unit_count;
  logic        modulus_set_select, frac_carry, power_down, counter_reset;
  logic        lock_detect, lock_window_wide, irq;
  int          n_errors, samples_checked, n_carry;

  fnd_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .ser_clk, .ser_data, .ser_le, .ref_div_clk, .fb_div_clk, .phase_err, .coarse_count, .quad_count,
    .unit_count, .modulus_set_select, .frac_carry, .power_down, .counter_reset, .lock_detect,
    .lock_window_wide, .irq);
  fnd_host host (.pclk, .ser_clk, .ser_data, .ser_le);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) if (frac_carry === 1'b1) n_carry <= n_carry + 1;

  // -------------------------------------------------
  // Helpers
  // -------------------------------------------------
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    last_err = pslverr;
    if (n >= 20) chk("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(w, q, e);
  endtask

  function automatic logic [23:0] mk(input logic [2:0] c, input logic [14:0] n, input logic [3:0] f);
    return {c, n, f, SEL_RF_WORD};
  endfunction

  // One reference cycle of 8 pclk stands for a legal reference divide
  task automatic refc(input logic e);
    phase_err <= e;
    repeat (2) @(posedge pclk);
    ref_div_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    ref_div_clk <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic fbc();
    fb_div_clk <= 1'b1;
    repeat (3) @(posedge pclk);
    fb_div_clk <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // -------------------------------------------------
  // Scenarios
  // -------------------------------------------------
  task automatic t_regs();
    rchk(OFS_CTRL, {31'h0, CTRL_MOD16_RST}, "ctrl_rst");
    rchk(OFS_IRQ_EN, {28'h0, IRQ_EN_RST}, "irq_en_rst");
    wr(OFS_IRQ_EN, 32'h0000000F);
    rchk(OFS_IRQ_EN, 32'h0000000F, "irq_en");
    wr(OFS_SETTING, 32'h00FFFFFF);
    rchk(OFS_SETTING, 32'h0, "setting_ro");
    rchk(8'h1C, 32'h0, "unmapped");
    chk("slverr", last_err, 1'b1);
    rchk(OFS_IRQ_CLR, 32'h0, "clr_reads");
    wr(OFS_IRQ_EN, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_dec();
    logic [14:0] nv[7];
    logic [4:0]  p;
    logic [10:0] c;
    logic [1:0]  q;
    logic [23:0] w;
    nv = '{15'd24, 15'd41, 15'd16383, 15'd48, 15'd81, 15'd1234, 15'd32767};
    for (int i = 0; i < 7; i++) begin
      p = (i > 2) ? PRE_HIGH_P : PRE_LOW_P;
      c = 11'(nv[i] / p);
      q = 2'((nv[i] - c * p) / 4);
      w = mk({2'b00, i > 2}, nv[i], 4'(i));
      host.send(w);
      chk("coarse", coarse_count, c);
      chk("quad", quad_count, q);
      chk("unit", unit_count, nv[i] % 4);
      chk("msel", modulus_set_select, i > 2);
      rchk(OFS_SETTING, {8'h00, w}, "setting");
      rchk(OFS_DECODE, {13'h0, 4'(i), c, q, nv[i][1:0]}, "decode");
    end
    host.send(w ^ 24'h000001);
    rchk(OFS_SETTING, {8'h00, w}, "refused");
    wr(OFS_IRQ_CLR, 32'h0000000F);
    // Coarse margin broken on purpose
    host.send(mk(3'b110, 15'd31, 4'h0));
    chk("pwdn", power_down, 1'b1);
    chk("crst", counter_reset, 1'b1);
    rchk(OFS_STATUS, 32'h9, "bad_ratio");
    chk("irq_off", irq, 1'b0);
    wr(OFS_IRQ_EN, 32'h8);
    chk("irq_on", irq, 1'b1);
    wr(OFS_IRQ_CLR, 32'hF);
    chk("irq_clr", irq, 1'b0);
    $display("t_dec done");
  endtask

  task automatic t_lock();
    host.send(mk(3'b000, 15'd100, 4'h0));
    wr(OFS_IRQ_CLR, 32'hF);
    wr(OFS_IRQ_EN, 32'h2);
    repeat (4) refc(1'b0);
    refc(1'b1);
    repeat (4) refc(1'b0);
    chk("lock_restart", lock_detect, 1'b0);
    refc(1'b0);
    chk("lock_set", lock_detect, 1'b1);
    chk("wide", lock_window_wide, 1'b1);
    chk("irq_lock", irq, 1'b1);
    refc(1'b1);
    chk("lock_drop", lock_detect, 1'b0);
    rchk(OFS_STATUS, 32'h6, "lock_events");
    repeat (5) refc(1'b0);
    chk("relock", lock_detect, 1'b1);
    host.send(mk(3'b010, 15'd100, 4'h0));
    chk("pwdn_lock", lock_detect, 1'b0);
    repeat (6) refc(1'b0);
    chk("pwdn_hold", lock_detect, 1'b0);
    $display("t_lock done");
  endtask

  task automatic t_frac();
    int c0;
    host.send(mk(3'b000, 15'd100, 4'h3));
    c0 = n_carry;
    repeat (15) fbc();
    chk("carry15", n_carry - c0, 3);
    wr(OFS_CTRL, 32'h1);
    c0 = n_carry;
    repeat (15) fbc();
    chk("carry16", n_carry - c0, 2);
    rchk(OFS_CTRL, 32'h1, "ctrl_rw");
    // All-ones numerator: legal with modulus 16, flagged with modulus 15
    wr(OFS_IRQ_CLR, 32'hF);
    host.send(mk(3'b000, 15'd100, FRAC_ALL_ONES));
    rchk(OFS_STATUS, 32'h1, "ones_mod16");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_CLR, 32'hF);
    host.send(mk(3'b000, 15'd100, FRAC_ALL_ONES));
    rchk(OFS_STATUS, 32'h9, "ones_mod15");
    $display("t_frac done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {ref_div_clk, fb_div_clk, phase_err} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_dec();
    t_lock();
    t_frac();
    stop_test();
  end

  // Whole run is near 0.35 ms
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
endmodule // tb_fnd_top

`default_nettype wire
